// file: verilog/ccs_pkg.sv
`default_nettype none
package ccs_pkg;
	// ************************************************************
	// register map, one aligned word each
	// ************************************************************
	localparam logic [7:0] REG_CMD     = 8'h00;
	localparam logic [7:0] REG_PSW     = 8'h04;
	localparam logic [7:0] REG_STATUS  = 8'h08;
	localparam logic [7:0] REG_BUSCTL  = 8'h0c;
	localparam logic [7:0] REG_BUSDATA = 8'h10;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// command word fields
	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_AM_LSB   = 4;
	localparam int CMD_MASK_LSB = 8;
	localparam int CMD_CC_LSB   = 12;
	localparam int CMD_SRC_LSB  = 16;
	// bus control word fields
	localparam int BCT_ST_LSB   = 0;
	localparam int BCT_WR_BIT   = 4;
	localparam int BCT_ADDR_LSB = 16;
	// status word fields
	localparam int STS_BUSY_BIT  = 0;
	localparam int STS_CC_BIT    = 1;
	localparam int STS_PRIV_BIT  = 2;
	localparam int STS_REFU_BIT  = 3;
	localparam int STS_GRANT_BIT = 4;
	localparam int STS_BBUSY_BIT = 5;
	localparam int STS_MMIN_BIT  = 6;
	localparam int STS_RES_LSB   = 16;

	// ************************************************************
	// program status and flags
	// ************************************************************
	localparam int FLG_C  = 7;
	localparam int FLG_Z  = 6;
	localparam int FLG_S  = 5;
	localparam int FLG_PV = 4;
	localparam int PSW_SYS_BIT = 14;
	localparam logic [15:0] PSW_RESET = 16'h4000;

	typedef enum logic [3:0] {
		OP_NOP, OP_LOAD_FLAGS, OP_STORE_FLAGS, OP_LOAD_PSW, OP_MM_TEST,
		OP_MM_ASSERT, OP_MM_CLEAR, OP_FLAG_SET, OP_FLAG_CLEAR, OP_FLAG_INVERT,
		OP_COND_TEST, OP_MM_REQUEST
	} ccs_op_e;

	localparam logic [1:0] AM_IR = 2'h0;
	localparam logic [1:0] AM_DA = 2'h1;
	localparam logic [1:0] AM_X  = 2'h2;

	localparam logic [4:0] CYC_SHORT  = 5'h07;
	localparam logic [4:0] CYC_MM_SET = 5'h05;
	localparam logic [4:0] CYC_PS_IR  = 5'h0c;
	localparam logic [4:0] CYC_PS_DA  = 5'h10;
	localparam logic [4:0] CYC_PS_X   = 5'h11;
	localparam logic [4:0] CYC_MM_REQ = 5'h0c;

	// ************************************************************
	// condition field, aliases share one value
	// ************************************************************
	localparam logic [3:0] CC_NEVER  = 4'h0;
	localparam logic [3:0] CC_LT     = 4'h1;
	localparam logic [3:0] CC_LE     = 4'h2;
	localparam logic [3:0] CC_ULE    = 4'h3;
	localparam logic [3:0] CC_OV     = 4'h4;
	localparam logic [3:0] CC_PE     = 4'h4;
	localparam logic [3:0] CC_MI     = 4'h5;
	localparam logic [3:0] CC_Z      = 4'h6;
	localparam logic [3:0] CC_EQ     = 4'h6;
	localparam logic [3:0] CC_C      = 4'h7;
	localparam logic [3:0] CC_ULT    = 4'h7;
	localparam logic [3:0] CC_ALWAYS = 4'h8;
	localparam logic [3:0] CC_GE     = 4'h9;
	localparam logic [3:0] CC_GT     = 4'ha;
	localparam logic [3:0] CC_UGT    = 4'hb;
	localparam logic [3:0] CC_NOV    = 4'hc;
	localparam logic [3:0] CC_PO     = 4'hc;
	localparam logic [3:0] CC_PL     = 4'hd;
	localparam logic [3:0] CC_NZ     = 4'he;
	localparam logic [3:0] CC_NE     = 4'he;
	localparam logic [3:0] CC_NC     = 4'hf;
	localparam logic [3:0] CC_UGE    = 4'hf;

	// ************************************************************
	// bus cycle status codes
	// ************************************************************
	localparam logic [3:0] ST_INTERNAL  = 4'h0;
	localparam logic [3:0] ST_REFRESH   = 4'h1;
	localparam logic [3:0] ST_IO        = 4'h2;
	localparam logic [3:0] ST_SPECIAL_IO = 4'h3;
	localparam logic [3:0] ST_ACK_TRAP  = 4'h4;
	localparam logic [3:0] ST_ACK_NMI   = 4'h5;
	localparam logic [3:0] ST_ACK_NVI   = 4'h6;
	localparam logic [3:0] ST_ACK_VI    = 4'h7;
	localparam logic [3:0] ST_MEM_DATA  = 4'h8;
	localparam logic [3:0] ST_MEM_STACK = 4'h9;
	localparam logic [3:0] ST_EXT_DATA  = 4'ha;
	localparam logic [3:0] ST_EXT_STACK = 4'hb;
	localparam logic [3:0] ST_PROG_NTH  = 4'hc;
	localparam logic [3:0] ST_FETCH_1ST = 4'hd;
	localparam logic [3:0] ST_EXT_XFER  = 4'he;
	localparam logic [3:0] ST_RESERVED  = 4'hf;

	// data phase length, I/O adds one automatic wait
	localparam logic [1:0] BUS_T3_CYC = 2'h3;

	typedef enum logic [2:0] {BUS_IDLE, BUS_T1, BUS_T2, BUS_TW, BUS_T3} ccs_bus_e;
endpackage
`default_nettype wire

// file: verilog/ccs_cond_eval.sv
`timescale 1ns/1ps
`default_nettype none
module ccs_cond_eval
	import ccs_pkg::*;
(
	input  wire logic [3:0] cc_field,
	input  wire logic [7:0] flag_byte,
	output logic            cond_true
);
	logic c, z, s, v;
	assign c = flag_byte[FLG_C];
	assign z = flag_byte[FLG_Z];
	assign s = flag_byte[FLG_S];
	assign v = flag_byte[FLG_PV];

	always_comb begin
		case (cc_field)
			CC_NEVER:  cond_true = 1'b0;
			CC_ALWAYS: cond_true = 1'b1;
			CC_EQ:     cond_true = z;
			CC_NE:     cond_true = ~z;
			CC_ULT:    cond_true = c;
			CC_UGE:    cond_true = ~c;
			CC_MI:     cond_true = s;
			CC_PL:     cond_true = ~s;
			CC_PE:     cond_true = v;
			CC_PO:     cond_true = ~v;
			CC_GE:     cond_true = ~(s ^ v);
			CC_LT:     cond_true = s ^ v;
			CC_GT:     cond_true = ~(z | (s ^ v));
			CC_LE:     cond_true = z | (s ^ v);
			CC_UGT:    cond_true = ~c & ~z;
			CC_ULE:    cond_true = c | z;
			default:   cond_true = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// file: verilog/ccs_control.sv
`timescale 1ns/1ps
`default_nettype none
module ccs_control
	import ccs_pkg::*;
#(
	parameter int AD_W = 16
) (
	input  wire logic              sys_clk,
	input  wire logic              rstn,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic [AD_W-1:0]   addr_data_in,
	output logic [AD_W-1:0]        addr_data_out,
	output logic                   addr_data_oe_n,
	output logic                   address_strobe_n,
	output logic                   data_strobe_n,
	output logic                   memory_cycle_n,
	output logic [3:0]             bus_cycle_status,
	output logic                   ctrl_oe_n,
	input  wire logic              bus_request_n,
	output logic                   bus_grant_n,
	input  wire logic              mm_in_n,
	output logic                   mm_out_n
);
	if (AD_W < 8 || AD_W > 16) begin : g_bad_width
		$error("ccs_control: AD_W must lie in 8..16");
	end

	localparam int SW = AD_W + 2;

	// ************************************************************
	// pin synchronisers: a change counts once stages 2 and 3 agree
	// ************************************************************
	logic [SW-1:0] sy1_q, sy2_q, sy3_q, syf_q, syf_d;
	assign syf_d = (sy3_q & ~(sy2_q ^ sy3_q)) | (syf_q & (sy2_q ^ sy3_q));
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sy1_q <= '1;
			sy2_q <= '1;
			sy3_q <= '1;
			syf_q <= '1;
		end else begin
			sy1_q <= {bus_request_n, mm_in_n, addr_data_in};
			sy2_q <= sy1_q;
			sy3_q <= sy2_q;
			syf_q <= syf_d;
		end
	end
	logic            breq_n_f, mm_in_n_f;
	assign breq_n_f  = syf_q[SW-1];
	assign mm_in_n_f = syf_q[SW-2];

	// ************************************************************
	// AXI4-Lite slave
	// ************************************************************
	logic        aw_hold_q, w_hold_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        wr_fire;
	assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			aw_hold_q     <= 1'b0;
			awaddr_q      <= 8'h00;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_q     <= 1'b1;
			awaddr_q      <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else begin
			if (wr_fire)
				aw_hold_q <= 1'b0;
			s_axi_awready <= !aw_hold_q && !s_axi_bvalid;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			w_hold_q     <= 1'b0;
			wdata_q      <= 32'h0000_0000;
			wstrb_q      <= 4'h0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_hold_q     <= 1'b1;
			wdata_q      <= s_axi_wdata;
			wstrb_q      <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else begin
			if (wr_fire)
				w_hold_q <= 1'b0;
			s_axi_wready <= !w_hold_q && !s_axi_bvalid;
		end
	end

	logic wr_mapped;
	assign wr_mapped = awaddr_q[7:2] == REG_CMD[7:2] || awaddr_q[7:2] == REG_BUSCTL[7:2] ||
		awaddr_q[7:2] == REG_BUSDATA[7:2];

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// partial strobes cannot start half a command, so only a full word acts
	logic wr_full, cmd_wr, bus_wr, bdat_wr;
	assign wr_full = wr_fire && wstrb_q == 4'hf;
	assign cmd_wr  = wr_full && awaddr_q[7:2] == REG_CMD[7:2];
	assign bus_wr  = wr_full && awaddr_q[7:2] == REG_BUSCTL[7:2];
	assign bdat_wr = wr_full && awaddr_q[7:2] == REG_BUSDATA[7:2];

	// ************************************************************
	// instruction sequencer
	// ************************************************************
	logic [15:0] psw_q;
	logic        busy_q, priv_fault_q, refused_q, cc_res_q;
	logic [4:0]  cnt_q;
	ccs_op_e     op_q;
	logic [3:0]  mask_q, cc_q;
	logic [15:0] src_q, result_q;
	logic        sys_mode, op_priv, cond_true, exec_done, bus_refuse;
	ccs_op_e     new_op;
	logic [1:0]  new_am;
	logic [4:0]  new_len;
	logic [7:0]  mask_byte;

	assign sys_mode  = psw_q[PSW_SYS_BIT];
	assign new_op    = ccs_op_e'(wdata_q[CMD_OP_LSB +: 4]);
	assign new_am    = wdata_q[CMD_AM_LSB +: 2];
	assign op_priv   = new_op inside {OP_LOAD_PSW, OP_MM_TEST, OP_MM_REQUEST, OP_MM_ASSERT, OP_MM_CLEAR};
	assign exec_done = busy_q && cnt_q == 5'h00;
	assign mask_byte = {mask_q, 4'h0};

	always_comb begin
		case (new_op)
			OP_LOAD_PSW: new_len = new_am == AM_IR ? CYC_PS_IR : (new_am == AM_DA ? CYC_PS_DA : CYC_PS_X);
			OP_MM_ASSERT, OP_MM_CLEAR: new_len = CYC_MM_SET;
			OP_MM_REQUEST: new_len = CYC_MM_REQ;
			default: new_len = CYC_SHORT;
		endcase
	end

	ccs_cond_eval u_cond (
		.cc_field  (cc_q),
		.flag_byte (psw_q[7:0]),
		.cond_true (cond_true)
	);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			busy_q       <= 1'b0;
			cnt_q        <= 5'h00;
			op_q         <= OP_NOP;
			mask_q       <= 4'h0;
			cc_q         <= 4'h0;
			src_q        <= 16'h0000;
			priv_fault_q <= 1'b0;
		end else if (cmd_wr && !busy_q) begin
			if (op_priv && !sys_mode) begin
				priv_fault_q <= 1'b1;
			end else begin
				priv_fault_q <= 1'b0;
				busy_q       <= 1'b1;
				cnt_q        <= new_len - 5'h01;
				op_q         <= new_op;
				mask_q       <= wdata_q[CMD_MASK_LSB +: 4];
				cc_q         <= wdata_q[CMD_CC_LSB +: 4];
				src_q        <= wdata_q[CMD_SRC_LSB +: 16];
			end
		end else if (exec_done) begin
			busy_q <= 1'b0;
		end else if (busy_q) begin
			cnt_q <= cnt_q - 5'h01;
		end
	end

	// refused: command while busy, or bus cycle while busy, while a bus cycle runs, requested or granted
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			refused_q <= 1'b0;
		else if ((cmd_wr && busy_q) || bus_refuse)
			refused_q <= 1'b1;
		else if (cmd_wr || bus_wr)
			refused_q <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			psw_q    <= PSW_RESET;
			result_q <= 16'h0000;
			cc_res_q <= 1'b0;
		end else if (exec_done) begin
			case (op_q)
				OP_LOAD_FLAGS:  psw_q[7:0] <= src_q[7:0];
				OP_STORE_FLAGS: result_q   <= {8'h00, psw_q[7:0]};
				OP_LOAD_PSW:    psw_q      <= src_q;
				OP_MM_TEST, OP_MM_REQUEST: psw_q[FLG_S] <= ~mm_in_n_f;
				OP_FLAG_SET:    psw_q[7:0] <= psw_q[7:0] | mask_byte;
				OP_FLAG_CLEAR:  psw_q[7:0] <= psw_q[7:0] & ~mask_byte;
				OP_FLAG_INVERT: psw_q[7:0] <= psw_q[7:0] ^ mask_byte;
				OP_COND_TEST:   cc_res_q   <= cond_true;
				default: ;
			endcase
		end
	end

	// a request that finds the chain taken withdraws its own output again
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			mm_out_n <= 1'b1;
		else if (cmd_wr && !busy_q && sys_mode && new_op inside {OP_MM_ASSERT, OP_MM_REQUEST})
			mm_out_n <= 1'b0;
		else if (exec_done && (op_q == OP_MM_CLEAR || (op_q == OP_MM_REQUEST && mm_in_n_f)))
			mm_out_n <= 1'b1;
	end

	// ************************************************************
	// bus cycle engine and pins
	// ************************************************************
	ccs_bus_e        bst_q;
	logic [3:0]      bcode_q;
	logic            bwr_q;
	logic [AD_W-1:0] baddr_q, bwdata_q, brdata_q;
	logic [1:0]      t3_q;
	logic            rd_pend_q;
	logic            bus_start, is_mem;

	assign bus_start  = bus_wr && bst_q == BUS_IDLE && bus_grant_n && !busy_q && breq_n_f;
	assign bus_refuse = bus_wr && !bus_start;
	assign is_mem     = wdata_q[BCT_ST_LSB +: 4] inside {[ST_MEM_DATA:ST_FETCH_1ST]};

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			bwdata_q <= '0;
		else if (bdat_wr)
			bwdata_q <= wdata_q[AD_W-1:0];
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			bst_q            <= BUS_IDLE;
			bcode_q          <= ST_INTERNAL;
			bwr_q            <= 1'b0;
			baddr_q          <= '0;
			t3_q             <= 2'h0;
			addr_data_out    <= '0;
			addr_data_oe_n   <= 1'b1;
			address_strobe_n <= 1'b1;
			data_strobe_n    <= 1'b1;
			memory_cycle_n   <= 1'b1;
			bus_cycle_status <= ST_INTERNAL;
		end else begin
			case (bst_q)
				BUS_IDLE: begin
					if (bus_start) begin
						bst_q            <= BUS_T1;
						bcode_q          <= wdata_q[BCT_ST_LSB +: 4];
						bwr_q            <= wdata_q[BCT_WR_BIT];
						baddr_q          <= wdata_q[BCT_ADDR_LSB +: AD_W];
						addr_data_out    <= wdata_q[BCT_ADDR_LSB +: AD_W];
						addr_data_oe_n   <= 1'b0;
						address_strobe_n <= 1'b0;
						memory_cycle_n   <= !is_mem;
						bus_cycle_status <= wdata_q[BCT_ST_LSB +: 4];
					end
				end
				BUS_T1: begin
					bst_q            <= BUS_T2;
					address_strobe_n <= 1'b1;
				end
				BUS_T2: begin
					bst_q          <= (bcode_q == ST_IO || bcode_q == ST_SPECIAL_IO) ? BUS_TW : BUS_T3;
					t3_q           <= BUS_T3_CYC - 2'h1;
					data_strobe_n  <= 1'b0;
					addr_data_out  <= bwr_q ? bwdata_q : baddr_q;
					addr_data_oe_n <= !bwr_q;
				end
				BUS_TW: bst_q <= BUS_T3;
				BUS_T3: begin
					if (t3_q != 2'h0) begin
						t3_q <= t3_q - 2'h1;
					end else begin
						bst_q            <= BUS_IDLE;
						data_strobe_n    <= 1'b1;
						addr_data_oe_n   <= 1'b1;
						memory_cycle_n   <= 1'b1;
						bus_cycle_status <= ST_INTERNAL;
					end
				end
				default: bst_q <= BUS_IDLE;
			endcase
		end
	end

	// the pin filter lags the lines, so read data is taken one edge after the strobe rises
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rd_pend_q <= 1'b0;
			brdata_q  <= '0;
		end else begin
			rd_pend_q <= bst_q == BUS_T3 && t3_q == 2'h0 && !bwr_q;
			if (rd_pend_q)
				brdata_q <= syf_d[AD_W-1:0];
		end
	end

	// grant only between bus cycles; held while the master keeps request low
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			bus_grant_n <= 1'b1;
			ctrl_oe_n   <= 1'b0;
		end else if (!breq_n_f && bst_q == BUS_IDLE && !bus_start) begin
			bus_grant_n <= 1'b0;
			ctrl_oe_n   <= 1'b1;
		end else if (breq_n_f) begin
			bus_grant_n <= 1'b1;
			ctrl_oe_n   <= 1'b0;
		end
	end

	// ************************************************************
	// read path
	// ************************************************************
	logic [31:0] rd_mux;
	logic        rd_ok;
	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_ok  = 1'b1;
		case (s_axi_araddr[7:2])
			REG_CMD[7:2]:     rd_mux = {16'h0000, 12'h000, op_q};
			REG_PSW[7:2]:     rd_mux = {16'h0000, psw_q};
			REG_STATUS[7:2]: begin
				rd_mux = {result_q, 16'h0000};
				rd_mux[STS_BUSY_BIT]  = busy_q;
				rd_mux[STS_CC_BIT]    = cc_res_q;
				rd_mux[STS_PRIV_BIT]  = priv_fault_q;
				rd_mux[STS_REFU_BIT]  = refused_q;
				rd_mux[STS_GRANT_BIT] = !bus_grant_n;
				rd_mux[STS_BBUSY_BIT] = bst_q != BUS_IDLE || rd_pend_q;
				rd_mux[STS_MMIN_BIT]  = !mm_in_n_f;
			end
			REG_BUSCTL[7:2]:  rd_mux = {16'h0000, 12'h000, bcode_q};
			REG_BUSDATA[7:2]: rd_mux[AD_W-1:0] = brdata_q;
			default:          rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_mux;
			s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else begin
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			s_axi_arready <= !s_axi_rvalid;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	sequence s_addr_phase;
		!address_strobe_n && !addr_data_oe_n ##1 address_strobe_n;
	endsequence

	chk_flag_load_time: assert property (@(posedge sys_clk) disable iff (!rstn)
		$rose(busy_q) && op_q == OP_LOAD_FLAGS |-> busy_q [*7] ##1 !busy_q)
		else $error("flag byte load not 7 cycles");
	chk_psw_load_time: assert property (@(posedge sys_clk) disable iff (!rstn)
		$rose(busy_q) && op_q == OP_LOAD_PSW && cnt_q == CYC_PS_X - 5'h01 |-> ##16 busy_q ##1 !busy_q)
		else $error("indexed status load not 17 cycles");
	chk_psw_replace: assert property (@(posedge sys_clk) disable iff (!rstn)
		exec_done && op_q == OP_LOAD_PSW |=> psw_q == $past(src_q))
		else $error("program status not replaced");
	chk_mm_test_sign: assert property (@(posedge sys_clk) disable iff (!rstn)
		exec_done && op_q == OP_MM_TEST |=> psw_q[FLG_S] == !$past(mm_in_n_f))
		else $error("sign flag not from multi-micro input");
	chk_flag_set_mask: assert property (@(posedge sys_clk) disable iff (!rstn)
		exec_done && op_q == OP_FLAG_SET |=> (psw_q[7:0] & $past(mask_byte)) == $past(mask_byte))
		else $error("masked flags not set");
	chk_priv_refuse: assert property (@(posedge sys_clk) disable iff (!rstn)
		cmd_wr && !busy_q && op_priv && !sys_mode |=> priv_fault_q && !busy_q)
		else $error("privileged op ran in normal mode");
	chk_cond_never: assert property (@(posedge sys_clk) disable iff (!rstn)
		exec_done && op_q == OP_COND_TEST && cc_q == CC_NEVER |=> !cc_res_q)
		else $error("never condition came true");
	chk_ugt_flags: assert property (@(posedge sys_clk) disable iff (!rstn)
		exec_done && op_q == OP_COND_TEST && cc_q == CC_UGT |=>
		cc_res_q == !($past(psw_q[FLG_C]) || $past(psw_q[FLG_Z])))
		else $error("unsigned greater wrong");
	chk_addr_strobe: assert property (@(posedge sys_clk) disable iff (!rstn)
		s_addr_phase |-> addr_data_out == baddr_q ##1 !data_strobe_n)
		else $error("address not valid at strobe rise");
	chk_grant_float: assert property (@(posedge sys_clk) disable iff (!rstn)
		!bus_grant_n |-> addr_data_oe_n && ctrl_oe_n && bst_q == BUS_IDLE)
		else $error("bus driven while granted");
	chk_mem_cycle: assert property (@(posedge sys_clk) disable iff (!rstn)
		!memory_cycle_n |-> bus_cycle_status inside {[ST_MEM_DATA:ST_FETCH_1ST]})
		else $error("memory request on non-memory cycle");
endmodule
`default_nettype wire

// file: tb/ccs_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccs_bus_model (
	input  wire logic        sys_clk,
	input  wire logic [15:0] addr_data_out,
	input  wire logic        addr_data_oe_n,
	input  wire logic        data_strobe_n,
	input  wire logic [15:0] rd_word,
	input  wire logic        want_bus,
	output logic [15:0]      addr_data_in,
	output logic             bus_request_n
);
	logic [15:0] idle_q = 16'h5a5a;
	// ****
	// released lines toggle so a stale value never passes
	// ****
	always @(posedge sys_clk) idle_q <= ~idle_q;
	assign addr_data_in = !addr_data_oe_n ? addr_data_out : (!data_strobe_n ? rd_word : idle_q);
	always @(posedge sys_clk) bus_request_n <= !want_bus;
endmodule
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
	import ccs_pkg::*;
;
	logic        sys_clk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, want_bus, seen_m;
	logic        addr_data_oe_n, address_strobe_n, data_strobe_n, memory_cycle_n, ctrl_oe_n;
	logic        bus_request_n, bus_grant_n, mm_in_n, mm_out_n;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, s;
	logic [3:0]  s_axi_wstrb, bus_cycle_status, seen_st;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [15:0] addr_data_in, addr_data_out, rd_word, seen_a, seen_d;
	int          failures, cmp_count, cyc;
	ccs_control u_ccs_control (.*);
	ccs_bus_model u_ccs_bus_model (.*);
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// pre-edge values are what the bus held at that edge
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (!address_strobe_n) begin
			seen_a <= addr_data_out;
			seen_st <= bus_cycle_status;
			seen_m <= memory_cycle_n;
		end
		if (!data_strobe_n && !addr_data_oe_n)
			seen_d <= addr_data_out;
		if (cyc == 60000) begin
			failures++;
			end_sim();
		end
	end
	// ****
	// helpers
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_left, w_left;
		aw_left = 1'b1;
		w_left = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (aw_left || w_left) begin
			@(posedge sys_clk);
			if (aw_left && s_axi_awready) begin
				aw_left = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w_left && s_axi_wready) begin
				w_left = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge sys_clk); while (!s_axi_bvalid);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge sys_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge sys_clk); while (!s_axi_rvalid);
		d = s_axi_rdata;
	endtask
	task automatic cmd(input logic [31:0] w);
		wr(REG_CMD, w);
		do rd(REG_STATUS, s); while (s[STS_BUSY_BIT] || s[STS_BBUSY_BIT]);
	endtask
	task automatic bus(input logic [31:0] w);
		wr(REG_BUSCTL, w);
		do rd(REG_STATUS, s); while (s[STS_BBUSY_BIT]);
	endtask
	function automatic logic [31:0] mk(input ccs_op_e op, input logic [3:0] m, input logic [3:0] cc);
		return (32'(op) << CMD_OP_LSB) | (32'(m) << CMD_MASK_LSB) | (32'(cc) << CMD_CC_LSB);
	endfunction
	function automatic logic exp_cc(input logic [3:0] f, input logic [3:0] p);
		logic r;
		case (f[2:0])
			3'h0: r = 1'b0;
			3'h1: r = p[1] ^ p[0];
			3'h2: r = p[2] | (p[1] ^ p[0]);
			3'h3: r = p[3] | p[2];
			3'h4: r = p[0];
			3'h5: r = p[1];
			3'h6: r = p[2];
			default: r = p[3];
		endcase
		return r ^ f[3];
	endfunction
	// ****
	// scenarios
	// ****
	task automatic t_cond();
		for (int p = 0; p < 16; p++) begin
			cmd(mk(OP_FLAG_CLEAR, 4'hf, 4'h0));
			cmd(mk(OP_FLAG_SET, 4'(p), 4'h0));
			rd(REG_PSW, s);
			chk({28'h0, s[FLG_C], s[FLG_Z], s[FLG_S], s[FLG_PV]}, 32'(p));
			for (int c = 0; c < 16; c++) begin
				cmd(mk(OP_COND_TEST, 4'h0, 4'(c)));
				chk(32'(s[STS_CC_BIT]), 32'(exp_cc(4'(c), 4'(p))));
			end
		end
		cmd(mk(OP_FLAG_INVERT, 4'h5, 4'h0));
		rd(REG_PSW, s);
		chk(32'(s[7:4]), 32'ha);
		cmd(mk(OP_LOAD_FLAGS, 4'h0, 4'h0) | 32'h0096_0000);
		cmd(mk(OP_STORE_FLAGS, 4'h0, 4'h0));
		chk(32'(s[31:16]), 32'h0096);
		$display("condition test done");
	endtask
	task automatic t_bus();
		for (int c = 0; c < 16; c++) begin
			wr(REG_BUSDATA, 32'ha5c3 ^ 32'(c));
			bus({16'hbe00 | c[15:0], 11'h0, 1'b1, 4'(c)});
			chk(32'(seen_st), 32'(c));
			chk({seen_a, 15'h0, seen_m}, {16'hbe00 | c[15:0], 15'h0, 1'(c < 8 || c > 13)});
			chk(32'(seen_d), 32'ha5c3 ^ 32'(c));
		end
		for (int k = 0; k < 2; k++) begin
			rd_word <= 16'h3c5a ^ 16'(k);
			bus({16'h0100, 12'h0, k ? ST_MEM_DATA : ST_IO});
			rd(REG_BUSDATA, s);
			chk(32'(s[15:0]), 32'h3c5a ^ 32'(k));
			chk(32'(seen_m), 32'(k == 0));
		end
		$display("bus cycle test done");
	endtask
	task automatic t_grant();
		want_bus <= 1'b1;
		do @(posedge sys_clk); while (bus_grant_n);
		repeat (20) @(posedge sys_clk);
		chk({30'h0, ctrl_oe_n, bus_grant_n}, 32'h2);
		wr(REG_BUSCTL, 32'h0000_0010);
		rd(REG_STATUS, s);
		chk({29'h0, s[STS_GRANT_BIT], s[STS_REFU_BIT], s[STS_BBUSY_BIT]}, 32'h6);
		want_bus <= 1'b0;
		do @(posedge sys_clk); while (!bus_grant_n);
		$display("bus grant test done");
	endtask
	task automatic t_priv();
		for (int v = 0; v < 2; v++) begin
			mm_in_n <= v[0];
			repeat (6) @(posedge sys_clk);
			cmd(mk(OP_MM_TEST, 4'h0, 4'h0));
			rd(REG_PSW, s);
			chk(32'(s[FLG_S]), 32'(!v[0]));
		end
		cmd(mk(OP_MM_ASSERT, 4'h0, 4'h0));
		chk(32'(mm_out_n), 32'h0);
		cmd(mk(OP_MM_CLEAR, 4'h0, 4'h0));
		chk(32'(mm_out_n), 32'h1);
		cmd(mk(OP_MM_REQUEST, 4'h0, 4'h0));
		rd(REG_PSW, s);
		chk({30'h0, s[FLG_S], mm_out_n}, 32'h1);
		cmd(mk(OP_LOAD_PSW, 4'h0, 4'h0) | (32'(AM_X) << CMD_AM_LSB) | 32'h40f0_0000);
		rd(REG_PSW, s);
		chk(s, 32'h40f0);
		cmd(mk(OP_LOAD_PSW, 4'h0, 4'h0));
		rd(REG_PSW, s);
		chk(s, 32'h0);
		cmd(mk(OP_MM_TEST, 4'h0, 4'h0));
		chk(32'(s[STS_PRIV_BIT]), 32'h1);
		$display("privilege test done");
	endtask
	task automatic end_sim();
		$display("comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		rstn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, want_bus} = '0;
		{s_axi_bready, s_axi_rready, mm_in_n} = '1;
		s_axi_wstrb = 4'hf;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, rd_word} = '0;
		repeat (6) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (5) @(posedge sys_clk);
		rd(REG_PSW, s);
		chk(s, {16'h0, PSW_RESET});
		wr(8'h14, 32'h0);
		rd(8'h14, s);
		chk({28'h0, s_axi_bresp, s_axi_rresp}, {28'h0, RESP_SLVERR, RESP_SLVERR});
		t_cond();
		t_bus();
		t_grant();
		t_priv();
		end_sim();
	end
endmodule
`default_nettype wire
